// [ubd_dma.sv]
// Behaviour
// - zero total count ends the operation
// - total count from low and high halves
// - reload select picks address reload moment
// - burst field picks single or INCR4/8/16
// - writable base address, reset zero
// - current address is read only
// - enable and fifo clear bits
// - tx fifo full flag and level
// - rx fifo full flag and level
// - transfers only in dma mode
// - out packet sets rx run automatically
// - auto run disable cleared at end
// - out packet size loads per-operation count when rx run is set
//
// Register access over APB was decided locally.
`default_nettype none
`include "ubd_consts.svh"
module ubd_dma
    import ubd_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire ubd_apb_req_t apb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    output var ubd_ahb_req_t ahb_o,
    input wire logic [31:0] hrdata_i,
    input wire logic hready_i,
    input wire logic rx_valid_i,
    input wire logic [31:0] rx_data_i,
    output logic rx_ready_o,
    output logic tx_valid_o,
    output logic [31:0] tx_data_o,
    input wire logic tx_ready_i,
    input wire logic out_pkt_i,
    input wire logic [11:0] out_size_i,
    output logic irq_o
);
    ubd_state_t st_reg;
    ubd_state_t st_next;
    logic wr;
    logic dph;
    logic aph;
    logic start;

    function automatic logic ubd_mapped(input logic [31:0] a);
        case (a)
            `UBD_A_CTL, `UBD_A_PCNT, `UBD_A_TCL, `UBD_A_TCH, `UBD_A_DIFC, `UBD_A_BASE,
            `UBD_A_CUR, `UBD_A_FCTL, `UBD_A_FSTS, `UBD_A_ISTAT, `UBD_A_IMASK:
                return 1'b1;
            default:
                return 1'b0;
        endcase
    endfunction

    // saturates so a count that is not a word multiple still ends at zero
    function automatic logic [31:0] ubd_sub(input logic [31:0] v);
        return (v > `UBD_BEAT) ? v - `UBD_BEAT : `UBD_RST_WORD;
    endfunction

    function automatic logic [31:0] ubd_words(input logic [31:0] v);
        return {2'h0, v[31:2]} + {31'h0, |v[1:0]};
    endfunction

    assign wr = apb_i.psel && apb_i.penable && apb_i.pwrite;
    assign dph = st_reg.dpend && hready_i;
    assign aph = st_reg.ahb.htrans[1] && hready_i;

    always_comb
    begin
        logic [4:0] beats;
        logic [2:0] hb;
        logic [4:0] avail;
        logic [31:0] words;
        logic rpush;
        logic rpop;
        logic tpush;
        logic tpop;
        logic [1:0] ev;
        logic [1:0] iclr;
        beats = 5'h1;
        hb = `UBD_HB_SINGLE;
        avail = 5'h0;
        words = 32'h0;
        rpush = rx_valid_i && (st_reg.rxl != `UBD_LW'(`UBD_DEPTH));
        rpop = 1'b0;
        tpush = 1'b0;
        tpop = tx_ready_i && (st_reg.txl != '0);
        ev = 2'h0;
        iclr = 2'h0;
        start = 1'b0;
        st_next = st_reg;
        if (dph)
        begin
            st_next.dpend = 1'b0;
            tpush = !st_reg.ahb.hwrite;
            st_next.cur_addr = st_reg.cur_addr + `UBD_BEAT;
            st_next.tcnt = ubd_sub(st_reg.tcnt);
            st_next.pcnt = 12'(ubd_sub({20'h0, st_reg.pcnt}));
            if (st_next.pcnt == 12'h0)
            begin
                ev[0] = 1'b1;
                st_next.rxr = 1'b0;
                st_next.txr = 1'b0;
                if (st_reg.reload)
                    st_next.cur_addr = st_reg.base_addr;
            end
            if (st_next.tcnt == `UBD_RST_WORD)
            begin
                ev[1] = 1'b1;
                st_next.rxr = 1'b0;
                st_next.txr = 1'b0;
                st_next.ardis = 1'b0;
                if (!st_reg.reload)
                    st_next.cur_addr = st_reg.base_addr;
            end
            if (st_reg.fsm == UBD_DATA)
                st_next.fsm = UBD_IDLE;
        end
        if (aph)
        begin
            st_next.dpend = 1'b1;
            if (st_reg.ahb.hwrite)
            begin
                st_next.ahb.hwdata = st_reg.rxm[st_reg.rrp];
                rpop = 1'b1;
            end
            if (st_reg.alef != 5'h0)
            begin
                st_next.ahb.haddr = st_reg.ahb.haddr + `UBD_BEAT;
                st_next.ahb.htrans = `UBD_HT_SEQ;
                st_next.alef = st_reg.alef - 5'h1;
            end
            else
            begin
                st_next.ahb.htrans = `UBD_HT_IDLE;
                st_next.fsm = UBD_DATA;
            end
        end
        case (st_reg.burst)
            2'h1:
            begin
                beats = 5'h4;
                hb = `UBD_HB_INCR4;
            end
            2'h2:
            begin
                beats = 5'h8;
                hb = `UBD_HB_INCR8;
            end
            2'h3:
            begin
                beats = 5'h10;
                hb = `UBD_HB_INCR16;
            end
            default:
            begin
                beats = 5'h1;
                hb = `UBD_HB_SINGLE;
            end
        endcase
        avail = st_reg.rxr ? st_reg.rxl : `UBD_LW'(`UBD_DEPTH) - st_reg.txl;
        words = ubd_words(st_reg.tcnt);
        if (ubd_words({20'h0, st_reg.pcnt}) < words)
            words = ubd_words({20'h0, st_reg.pcnt});
        // the address phase never runs past what the fifo or counts allow
        if (st_reg.fsm == UBD_IDLE && st_reg.en && st_reg.mode && (st_reg.rxr || st_reg.txr)
            && st_reg.tcnt != `UBD_RST_WORD && st_reg.pcnt != 12'h0 && avail != 5'h0)
        begin
            start = 1'b1;
            if (avail < beats || words < {27'h0, beats})
            begin
                beats = 5'h1;
                hb = `UBD_HB_SINGLE;
            end
            st_next.ahb.haddr = st_reg.cur_addr;
            st_next.ahb.htrans = `UBD_HT_NSEQ;
            st_next.ahb.hburst = hb;
            st_next.ahb.hsize = `UBD_HSIZE_WORD;
            st_next.ahb.hwrite = st_reg.rxr;
            st_next.alef = beats - 5'h1;
            st_next.fsm = UBD_ADDR;
        end
        if (rpush)
        begin
            st_next.rxm[st_reg.rwp] = rx_data_i;
            st_next.rwp = st_reg.rwp + `UBD_PW'(1);
        end
        if (rpop)
            st_next.rrp = st_reg.rrp + `UBD_PW'(1);
        st_next.rxl = st_reg.rxl + {4'h0, rpush} - {4'h0, rpop};
        if (tpush)
        begin
            st_next.txm[st_reg.twp] = hrdata_i;
            st_next.twp = st_reg.twp + `UBD_PW'(1);
        end
        if (tpop)
            st_next.trp = st_reg.trp + `UBD_PW'(1);
        st_next.txl = st_reg.txl + {4'h0, tpush} - {4'h0, tpop};
        if (out_pkt_i && st_reg.mode && !st_reg.ardis)
            st_next.rxr = 1'b1;
        if (out_pkt_i && st_next.rxr)
            st_next.pcnt = out_size_i;
        if (wr)
        begin
            case (apb_i.paddr)
                `UBD_A_CTL:
                begin
                    st_next.mode = apb_i.pwdata[`UBD_B_MODE];
                    st_next.rxr = apb_i.pwdata[`UBD_B_RXR];
                    st_next.txr = apb_i.pwdata[`UBD_B_TXR];
                    st_next.ardis = apb_i.pwdata[`UBD_B_ARDIS];
                end
                `UBD_A_PCNT:
                    st_next.pcnt = apb_i.pwdata[11:0];
                `UBD_A_TCL:
                    st_next.tcnt[15:0] = apb_i.pwdata[15:0];
                `UBD_A_TCH:
                    st_next.tcnt[31:16] = apb_i.pwdata[15:0];
                `UBD_A_DIFC:
                begin
                    st_next.reload = apb_i.pwdata[`UBD_B_RELOAD];
                    st_next.burst = apb_i.pwdata[1:0];
                end
                `UBD_A_BASE:
                begin
                    st_next.base_addr = apb_i.pwdata;
                    if (st_reg.fsm == UBD_IDLE)
                        st_next.cur_addr = apb_i.pwdata;
                end
                `UBD_A_FCTL:
                begin
                    st_next.en = apb_i.pwdata[`UBD_B_EN];
                    // clear bits act once and read back as zero
                    if (apb_i.pwdata[`UBD_B_TFCLR])
                    begin
                        st_next.txl = '0;
                        st_next.twp = '0;
                        st_next.trp = '0;
                    end
                    if (apb_i.pwdata[`UBD_B_RFCLR])
                    begin
                        st_next.rxl = '0;
                        st_next.rwp = '0;
                        st_next.rrp = '0;
                    end
                end
                `UBD_A_ISTAT:
                    iclr = apb_i.pwdata[1:0];
                `UBD_A_IMASK:
                    st_next.imsk = apb_i.pwdata[1:0];
                default:
                    iclr = 2'h0;
            endcase
        end
        // a new event beats a same-cycle clear
        st_next.ist = (st_reg.ist & ~iclr) | ev;
        if (apb_i.psel && !apb_i.penable)
        begin
            case (apb_i.paddr)
                `UBD_A_CTL:
                    st_next.prdata = {26'h0, st_reg.ardis, 2'h0, st_reg.txr, st_reg.rxr,
                        st_reg.mode};
                `UBD_A_PCNT:
                    st_next.prdata = {20'h0, st_reg.pcnt};
                `UBD_A_TCL:
                    st_next.prdata = {16'h0, st_reg.tcnt[15:0]};
                `UBD_A_TCH:
                    st_next.prdata = {16'h0, st_reg.tcnt[31:16]};
                `UBD_A_DIFC:
                    st_next.prdata = {27'h0, st_reg.reload, 2'h0, st_reg.burst};
                `UBD_A_BASE:
                    st_next.prdata = st_reg.base_addr;
                `UBD_A_CUR:
                    st_next.prdata = st_reg.cur_addr;
                `UBD_A_FCTL:
                    st_next.prdata = {23'h0, st_reg.en, 8'h0};
                `UBD_A_FSTS:
                    st_next.prdata = {18'h0, st_reg.txl == `UBD_LW'(`UBD_DEPTH), st_reg.txl,
                        2'h0, st_reg.rxl == `UBD_LW'(`UBD_DEPTH), st_reg.rxl};
                `UBD_A_ISTAT:
                    st_next.prdata = {30'h0, st_reg.ist};
                `UBD_A_IMASK:
                    st_next.prdata = {30'h0, st_reg.imsk};
                default:
                    st_next.prdata = `UBD_RST_WORD;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            st_reg <= '0;
            st_reg.fsm <= UBD_IDLE;
        end
        else
            st_reg <= st_next;
    end

    assign ahb_o = st_reg.ahb;
    assign prdata_o = st_reg.prdata;
    assign pready_o = 1'b1;
    assign pslverr_o = apb_i.psel && apb_i.penable && !ubd_mapped(apb_i.paddr);
    assign rx_ready_o = st_reg.rxl != `UBD_LW'(`UBD_DEPTH);
    assign tx_valid_o = st_reg.txl != '0;
    assign tx_data_o = st_reg.txm[st_reg.trp];
    assign irq_o = |(st_reg.ist & st_reg.imsk);

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (sys_rst_i);

    a_stop_zero: assert property ((st_reg.tcnt == 32'h0 && st_reg.fsm == UBD_IDLE) |=>
        st_reg.fsm == UBD_IDLE && ahb_o.htrans == `UBD_HT_IDLE) else $error("issued at zero");
    a_count_high: assert property ((wr && apb_i.paddr == `UBD_A_TCH && !dph) |=>
        st_reg.tcnt[31:16] == $past(apb_i.pwdata[15:0])) else $error("high half lost");
    a_reload_end: assert property ((dph && st_reg.tcnt <= 32'h4 && !st_reg.reload && !wr) |=>
        st_reg.cur_addr == $past(st_reg.base_addr)) else $error("no reload at end");
    a_single_code: assert property ((start && st_reg.burst == 2'h0) |=>
        ahb_o.hburst == 3'h0 && ahb_o.htrans == 2'h2) else $error("not single");
    a_base_write: assert property ((wr && apb_i.paddr == `UBD_A_BASE) |=>
        st_reg.base_addr == $past(apb_i.pwdata)) else $error("base not written");
    a_cur_ro: assert property ((wr && apb_i.paddr == `UBD_A_CUR && !dph) |=>
        $stable(st_reg.cur_addr)) else $error("current address written");
    a_tx_clear: assert property ((wr && apb_i.paddr == `UBD_A_FCTL && apb_i.pwdata[4]) |=>
        st_reg.txl == 5'h0 && !tx_valid_o) else $error("tx fifo not cleared");
    a_tx_full: assert property (st_reg.txl == 5'h10 |->
        st_reg.twp == st_reg.trp && tx_valid_o) else $error("tx full inconsistent");
    a_rx_full: assert property ((st_reg.rxl == 5'h10 && !dph) |=>
        st_reg.rxl <= 5'h10) else $error("rx level overflow");
    a_mode_gate: assert property (start |-> st_reg.mode && st_reg.en
        ##1 ahb_o.htrans == 2'h2) else $error("start outside dma mode");
    a_auto_rx: assert property ((out_pkt_i && st_reg.mode && !st_reg.ardis && !wr) |=>
        st_reg.rxr && st_reg.pcnt == $past(out_size_i)) else $error("no auto rx run");
    a_ardis_clr: assert property ((dph && st_reg.tcnt <= 32'h4 && !wr) |=>
        !st_reg.ardis && !st_reg.rxr) else $error("disable bit kept");
    a_beat_count: assert property ((dph && !wr && st_reg.tcnt >= 32'h8) |=>
        st_reg.tcnt == $past(st_reg.tcnt) - 32'h4) else $error("count not stepped");
    a_short_tail: assert property ((start && st_reg.tcnt <= 32'h4) |=>
        ahb_o.hburst == 3'h0) else $error("burst past end");
endmodule
`default_nettype wire

// [ubd_consts.svh]
`ifndef UBD_CONSTS_SVH
`define UBD_CONSTS_SVH
`define UBD_A_CTL 32'h49800040
`define UBD_A_PCNT 32'h49800048
`define UBD_A_TCL 32'h4980004c
`define UBD_A_TCH 32'h49800050
`define UBD_A_DIFC 32'h49800084
`define UBD_A_BASE 32'h49800088
`define UBD_A_CUR 32'h4980008c
`define UBD_A_FCTL 32'h49800100
`define UBD_A_FSTS 32'h49800104
`define UBD_A_ISTAT 32'h49800108
`define UBD_A_IMASK 32'h4980010c
`define UBD_B_MODE 0
`define UBD_B_RXR 1
`define UBD_B_TXR 2
`define UBD_B_ARDIS 5
`define UBD_B_RELOAD 4
`define UBD_B_EN 8
`define UBD_B_TFCLR 4
`define UBD_B_RFCLR 0
`define UBD_B_TFFULL 13
`define UBD_B_TFCNT 8
`define UBD_B_RFFULL 5
`define UBD_B_RFCNT 0
`define UBD_DEPTH 16
`define UBD_PW 4
`define UBD_LW 5
`define UBD_BEAT 32'h4
`define UBD_RST_WORD 32'h0
`define UBD_HT_IDLE 2'h0
`define UBD_HT_NSEQ 2'h2
`define UBD_HT_SEQ 2'h3
`define UBD_HB_SINGLE 3'h0
`define UBD_HB_INCR4 3'h3
`define UBD_HB_INCR8 3'h5
`define UBD_HB_INCR16 3'h7
`define UBD_HSIZE_WORD 3'h2
`endif

// [ubd_pkg.sv]
`default_nettype none
`include "ubd_consts.svh"
package ubd_pkg;
    typedef enum logic [2:0] {UBD_IDLE = 3'b001, UBD_ADDR = 3'b010, UBD_DATA = 3'b100} ubd_fsm_t;
    typedef struct packed {
        logic [31:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } ubd_apb_req_t;
    typedef struct packed {
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic [2:0] hburst;
        logic [2:0] hsize;
        logic hwrite;
        logic [31:0] hwdata;
    } ubd_ahb_req_t;
    typedef logic [`UBD_DEPTH-1:0][31:0] ubd_mem_t;
    typedef struct packed {
        ubd_fsm_t fsm;
        ubd_ahb_req_t ahb;
        logic [4:0] alef;
        logic dpend;
        logic mode;
        logic rxr;
        logic txr;
        logic ardis;
        logic reload;
        logic [1:0] burst;
        logic en;
        logic [31:0] tcnt;
        logic [11:0] pcnt;
        logic [31:0] base_addr;
        logic [31:0] cur_addr;
        ubd_mem_t txm;
        ubd_mem_t rxm;
        logic [`UBD_PW-1:0] twp;
        logic [`UBD_PW-1:0] trp;
        logic [`UBD_PW-1:0] rwp;
        logic [`UBD_PW-1:0] rrp;
        logic [`UBD_LW-1:0] txl;
        logic [`UBD_LW-1:0] rxl;
        logic [1:0] ist;
        logic [1:0] imsk;
        logic [31:0] prdata;
    } ubd_state_t;
endpackage
`default_nettype wire

// [ubd_mem.sv]
`default_nettype none
module ubd_mem
    import ubd_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire ubd_ahb_req_t ahb_i,
    input wire logic stall_i,
    output logic [31:0] hrdata_o,
    output logic hready_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] mem [64];
    logic dph;
    logic dwr;
    logic [5:0] da;
    logic [31:0] last;
    assign hready_o = !stall_i;
    // junk outside a read data phase, so a late sample cannot pass
    assign hrdata_o = (dph && !dwr) ? mem[da] : ~last;
    always @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            dph <= 1'b0;
            dwr <= 1'b0;
            da <= 6'h0;
            last <= 32'h0;
        end
        else if (hready_o)
        begin
            if (dph && dwr)
                mem[da] <= ahb_i.hwdata;
            if (dph && !dwr)
                last <= mem[da];
            dph <= ahb_i.htrans[1];
            dwr <= ahb_i.hwrite;
            da <= ahb_i.haddr[7:2];
        end
    end
endmodule
`default_nettype wire

// [tb.sv]
`default_nettype none
`include "ubd_consts.svh"
module tb
    import ubd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    ubd_apb_req_t apb = '0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    ubd_ahb_req_t ahb;
    logic [31:0] hrdata;
    logic hready;
    logic rx_valid = 1'b0;
    logic [31:0] rx_data = 32'h0;
    logic rx_ready;
    logic tx_valid;
    logic [31:0] tx_data;
    logic tx_ready = 1'b0;
    logic out_pkt = 1'b0;
    logic [11:0] out_size = 12'h0;
    logic irq;
    logic stall = 1'b0;
    logic pop_en = 1'b0;
    logic [31:0] r;
    integer seed = 32'h0650;
    int fail_count = 0;
    int n_checks = 0;
    logic [32:0] rdq [$];
    logic [31:0] txq [$];
    logic [2:0] hbq [$];
    logic [31:0] w [8];
    logic [31:0] regs [11] = '{`UBD_A_CTL, `UBD_A_PCNT, `UBD_A_TCL, `UBD_A_TCH, `UBD_A_DIFC,
        `UBD_A_BASE, `UBD_A_CUR, `UBD_A_FCTL, `UBD_A_FSTS, `UBD_A_ISTAT, `UBD_A_IMASK};

    ubd_dma i_ubd_dma (.sys_clk_i(clk), .sys_rst_i(rst), .apb_i(apb), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .ahb_o(ahb), .hrdata_i(hrdata),
        .hready_i(hready), .rx_valid_i(rx_valid), .rx_data_i(rx_data), .rx_ready_o(rx_ready),
        .tx_valid_o(tx_valid), .tx_data_o(tx_data), .tx_ready_i(tx_ready),
        .out_pkt_i(out_pkt), .out_size_i(out_size), .irq_o(irq));
    ubd_mem i_ubd_mem (.sys_clk_i(clk), .sys_rst_i(rst), .ahb_i(ahb), .stall_i(stall),
        .hrdata_o(hrdata), .hready_o(hready));

    initial
    begin
        forever #10 clk = ~clk;
    end

    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic xfer(input logic [31:0] a, input logic wr, input logic [31:0] d);
        int n;
        n = 0;
        apb <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: wr, pwdata: d};
        @(posedge clk);
        apb.penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 50)
        begin
            @(posedge clk);
            n++;
        end
        if (n >= 50)
            fail_count++;
        apb.psel <= 1'b0;
        apb.penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        rdq.push_back({1'b0, e});
        xfer(a, 1'b0, 32'h0);
    endtask

    task automatic push(input logic [31:0] d);
        int n;
        n = 0;
        rx_valid <= 1'b1;
        rx_data <= d;
        @(posedge clk);
        while (rx_ready !== 1'b1 && n < 50)
        begin
            @(posedge clk);
            n++;
        end
        if (n >= 50)
            fail_count++;
        rx_valid <= 1'b0;
        @(posedge clk);
    endtask

    task automatic pulse(input logic [11:0] s);
        out_pkt <= 1'b1;
        out_size <= s;
        @(posedge clk);
        out_pkt <= 1'b0;
        @(posedge clk);
    endtask

    task automatic irq_is(input logic e);
        int n;
        n = 0;
        @(negedge clk);
        // a completion flag may take a while; give it a bounded wait
        while (e && irq !== 1'b1 && n < 3000)
        begin
            @(negedge clk);
            n++;
        end
        chk(irq, e);
        @(posedge clk);
    endtask

    always @(posedge clk)
    begin
        r = $random(seed);
        stall <= r[0];
        tx_ready <= pop_en & r[1];
        if (apb.psel && apb.penable && pready && !apb.pwrite)
            chk({pslverr, prdata}, rdq.pop_front());
        if (tx_valid && tx_ready)
            chk(tx_data, txq.pop_front());
        if (ahb.htrans == `UBD_HT_NSEQ && hready)
            hbq.push_back(ahb.hburst);
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        fail_count++;
        results();
    end

    initial
    begin
        int n;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        foreach (regs[k])
            rd(regs[k], `UBD_RST_WORD);
        wr(32'h49800200, 32'hffffffff);
        rdq.push_back({1'b1, 32'h0});
        xfer(32'h49800200, 1'b0, 32'h0);
        $display("test reset done");
        w[0] = $random(seed) & 32'hfffffffc;
        wr(`UBD_A_BASE, w[0]);
        rd(`UBD_A_BASE, w[0]);
        wr(`UBD_A_CUR, ~w[0]);
        rd(`UBD_A_CUR, w[0]);
        wr(`UBD_A_DIFC, 32'hffffffff);
        rd(`UBD_A_DIFC, 32'h13);
        wr(`UBD_A_TCL, 32'hffff1234);
        rd(`UBD_A_TCL, 32'h1234);
        wr(`UBD_A_TCH, 32'habcd5678);
        rd(`UBD_A_TCH, 32'h5678);
        $display("test registers done");
        for (int k = 0; k < 16; k++)
            push($random(seed));
        rd(`UBD_A_FSTS, 32'h30);
        wr(`UBD_A_FCTL, 32'h1);
        rd(`UBD_A_FSTS, 32'h0);
        rd(`UBD_A_FCTL, 32'h0);
        $display("test fifo done");
        for (int k = 0; k < 6; k++)
        begin
            w[k] = $random(seed);
            i_ubd_mem.mem[16+k] = w[k];
        end
        wr(`UBD_A_BASE, 32'h40);
        wr(`UBD_A_DIFC, 32'h11);
        wr(`UBD_A_TCL, 32'd24);
        wr(`UBD_A_TCH, 32'h0);
        wr(`UBD_A_PCNT, 32'h100);
        wr(`UBD_A_IMASK, 32'h2);
        wr(`UBD_A_CTL, 32'h5);
        hbq.delete();
        wr(`UBD_A_FCTL, 32'h100);
        irq_is(1'b1);
        rd(`UBD_A_FSTS, 32'h0600);
        rd(`UBD_A_CUR, 32'h58);
        rd(`UBD_A_TCL, 32'h0);
        rd(`UBD_A_CTL, 32'h1);
        chk(hbq.size(), 3);
        chk(hbq[0], `UBD_HB_INCR4);
        chk(hbq[2], `UBD_HB_SINGLE);
        for (int k = 0; k < 6; k++)
            txq.push_back(w[k]);
        pop_en <= 1'b1;
        n = 0;
        while (txq.size() != 0 && n < 500)
        begin
            @(posedge clk);
            n++;
        end
        pop_en <= 1'b0;
        chk(txq.size(), 0);
        wr(`UBD_A_IMASK, 32'h0);
        irq_is(1'b0);
        wr(`UBD_A_IMASK, 32'h2);
        irq_is(1'b1);
        wr(`UBD_A_ISTAT, 32'h2);
        irq_is(1'b0);
        rd(`UBD_A_ISTAT, 32'h0);
        $display("test tx done");
        wr(`UBD_A_FCTL, 32'h0);
        wr(`UBD_A_CTL, 32'h21);
        pulse(12'd8);
        rd(`UBD_A_CTL, 32'h21);
        wr(`UBD_A_CTL, 32'h1);
        pulse(12'd8);
        rd(`UBD_A_CTL, 32'h3);
        rd(`UBD_A_PCNT, 32'h8);
        wr(`UBD_A_CTL, 32'h23);
        wr(`UBD_A_BASE, 32'h80);
        wr(`UBD_A_DIFC, 32'h0);
        wr(`UBD_A_TCL, 32'd8);
        for (int k = 0; k < 2; k++)
        begin
            w[k] = $random(seed);
            push(w[k]);
        end
        wr(`UBD_A_FCTL, 32'h100);
        irq_is(1'b1);
        rd(`UBD_A_CTL, 32'h1);
        rd(`UBD_A_CUR, 32'h80);
        rd(`UBD_A_ISTAT, 32'h3);
        chk(i_ubd_mem.mem[32], w[0]);
        chk(i_ubd_mem.mem[33], w[1]);
        $display("test rx done");
        // packet end before total end, with reload per packet and a full tx fifo
        wr(`UBD_A_ISTAT, 32'h3);
        wr(`UBD_A_IMASK, 32'h1);
        wr(`UBD_A_BASE, 32'h80);
        wr(`UBD_A_DIFC, 32'h13);
        wr(`UBD_A_TCL, 32'h80);
        wr(`UBD_A_PCNT, 32'h40);
        hbq.delete();
        wr(`UBD_A_CTL, 32'h5);
        irq_is(1'b1);
        rd(`UBD_A_CUR, 32'h80);
        rd(`UBD_A_TCL, 32'h40);
        rd(`UBD_A_FSTS, 32'h3000);
        rd(`UBD_A_ISTAT, 32'h1);
        chk(hbq.size(), 1);
        chk(hbq[0], `UBD_HB_INCR16);
        wr(`UBD_A_FCTL, 32'h110);
        rd(`UBD_A_FSTS, 32'h0);
        $display("test packet reload done");
        results();
    end
endmodule
`default_nettype wire
